/* src/saf_pkg.sv */
// constants, register map and rate decoding for the sinc5 averager decimator
// assumes a single master clock domain shared by all users of this package
package saf_pkg;

   // --------------------------------------------------------------------
   // filter structure
   // --------------------------------------------------------------------
   localparam int unsigned  MOD_DIV      = 4;
   localparam int unsigned  SINC_ORDER   = 5;
   localparam int unsigned  SINC_DECIM   = 64;
   localparam int unsigned  SINC_W       = 32;
   localparam int unsigned  ACC_W        = 46;
   localparam int unsigned  CNT_W        = 14;
   localparam int unsigned  DATA_W       = 24;
   localparam int unsigned  OUT_SHIFT    = 7;
   localparam logic [2:0]   SETTLE_N     = 3'h4;
   localparam logic [5:0]   DIV_STEPS    = 6'h2e;

   // --------------------------------------------------------------------
   // input switch timing, in master clocks
   // --------------------------------------------------------------------
   localparam logic [1:0]   PERIOD_LO    = 2'h3;
   localparam logic [1:0]   PERIOD_HI    = 2'h1;
   localparam logic [2:0]   GAIN_FAST    = 3'h5;

   // --------------------------------------------------------------------
   // register map
   // --------------------------------------------------------------------
   localparam logic [1:0]   ADDR_STATUS  = 2'h0;
   localparam logic [1:0]   ADDR_CTRL    = 2'h2;
   localparam logic [1:0]   ADDR_RATE    = 2'h3;
   localparam int unsigned  INPUT_BUFFER_ENABLE_BIT_POS    = 1;
   localparam int unsigned  READY_POS    = 0;
   localparam logic [7:0]   RATE_RESET   = 8'hf0;
   localparam logic [CNT_W-1:0] CNT_RESET = 14'h0001;
   localparam logic [2:0]   GAIN_RESET   = 3'h0;

   // returns {valid, average count}
   function automatic logic [CNT_W:0] rate_decode(input logic [7:0] code);
      unique case (code)
         8'h03:   rate_decode = {1'b1, 14'd12000};
         8'h13:   rate_decode = {1'b1, 14'd6000};
         8'h23:   rate_decode = {1'b1, 14'd3000};
         8'h33:   rate_decode = {1'b1, 14'd2000};
         8'h43:   rate_decode = {1'b1, 14'd1200};
         8'h53:   rate_decode = {1'b1, 14'd1000};
         8'h63:   rate_decode = {1'b1, 14'd600};
         8'h72:   rate_decode = {1'b1, 14'd500};
         8'h82:   rate_decode = {1'b1, 14'd300};
         8'h92:   rate_decode = {1'b1, 14'd60};
         8'ha1:   rate_decode = {1'b1, 14'd30};
         8'hb0:   rate_decode = {1'b1, 14'd15};
         8'hc0:   rate_decode = {1'b1, 14'd8};
         8'hd0:   rate_decode = {1'b1, 14'd4};
         8'he0:   rate_decode = {1'b1, 14'd2};
         8'hf0:   rate_decode = {1'b1, 14'd1};
         default: rate_decode = {1'b0, 14'd0};
      endcase
   endfunction

endpackage

/* src/saf_sinc5.sv */
// fifth-order sinc decimator by 64 on a one-bit modulator stream
// assumes sample_en_i pulses once per modulator sample
`timescale 1ns/1ps
module saf_sinc5 import saf_pkg::*; (
   input  wire logic                     ref_clk_i,
   input  wire logic                     reset_i,
   input  wire logic                     clear_i,
   input  wire logic                     sample_en_i,
   input  wire logic                     bit_i,
   output logic signed [SINC_W-1:0]      result_o,
   output logic                          result_valid_o
);

   // modular arithmetic: integrator wrap cancels in the combs
   logic signed [SINC_W-1:0] integ_q [SINC_ORDER];
   logic signed [SINC_W-1:0] dly_q   [SINC_ORDER];
   logic signed [SINC_W-1:0] comb_v  [SINC_ORDER+1];
   logic        [5:0]        phase_q;
   logic                     decim;

   assign decim = sample_en_i && (phase_q == 6'(SINC_DECIM - 1));

   always_comb begin
      comb_v[0] = integ_q[SINC_ORDER-1];
      for (int k = 0; k < SINC_ORDER; k++) begin
         comb_v[k+1] = comb_v[k] - dly_q[k];
      end
   end

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         for (int k = 0; k < SINC_ORDER; k++) begin
            integ_q[k] <= '0;
            dly_q[k]   <= '0;
         end
         phase_q        <= '0;
         result_o       <= '0;
         result_valid_o <= 1'b0;
      end else if (clear_i) begin
         for (int k = 0; k < SINC_ORDER; k++) begin
            integ_q[k] <= '0;
            dly_q[k]   <= '0;
         end
         phase_q        <= '0;
         result_valid_o <= 1'b0;
      end else begin
         result_valid_o <= decim;
         if (sample_en_i) begin
            integ_q[0] <= integ_q[0] + (bit_i ? 32'sh1 : -32'sh1);
            for (int k = 1; k < SINC_ORDER; k++) begin
               integ_q[k] <= integ_q[k] + integ_q[k-1];
            end
            phase_q <= phase_q + 6'h1;
         end
         if (decim) begin
            for (int k = 0; k < SINC_ORDER; k++) begin
               dly_q[k] <= comb_v[k];
            end
            result_o <= comb_v[SINC_ORDER];
         end
      end
   end

endmodule

/* src/saf_buf2.sv */
// small fifo with valid/ready on both sides, read data from flip-flops
// assumes DEPTH is a power of two
`timescale 1ns/1ps
module saf_buf2 #(
   parameter int unsigned WIDTH = 24,
   parameter int unsigned DEPTH = 2
) (
   input  wire logic             ref_clk_i,
   input  wire logic             reset_i,
   input  wire logic             flush_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);

   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0]    wr_q;
   logic [PW-1:0]    rd_q;
   logic [PW:0]      fill_q;
   logic             push;
   logic             pop;

   assign in_ready_o  = (fill_q != (PW+1)'(DEPTH));
   assign out_valid_o = (fill_q != '0);
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;
   assign out_data_o  = mem_q[rd_q];

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         wr_q   <= '0;
         rd_q   <= '0;
         fill_q <= '0;
         for (int k = 0; k < DEPTH; k++) begin
            mem_q[k] <= '0;
         end
      end else if (flush_i) begin
         wr_q   <= '0;
         rd_q   <= '0;
         fill_q <= '0;
      end else begin
         if (push) begin
            mem_q[wr_q] <= in_data_i;
            wr_q        <= wr_q + PW'(1);
         end
         if (pop) begin
            rd_q <= rd_q + PW'(1);
         end
         fill_q <= fill_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

endmodule

/* src/saf_top.sv */
// decimation filter and front-end control of a 24-bit delta-sigma converter
// assumes modulator bit, register port and sync inputs are synchronous to ref_clk_i
//
// Summary of operation
// - take one modulator sample every four master clocks
// - first stage is a fifth-order sinc decimating by 64
// - second stage averages a register-selected count of first-stage results
// - output rate is modulator rate over 64 over the average count
// - codes 03h..63h select 12000, 6000, 3000, 2000, 1200, 1000, 600
// - codes 72h..E0h select 500 down to 2; F0h bypasses the averager
// - only sixteen rate codes are valid settings
// - all timing derives from the master clock, rate scales with it
// - combined response is sinc5 times averager, notches at output rate multiples
// - input buffer follows the enable bit of the status register
// - gain is chosen in the control register, powers of two 1 to 128
// - input sample cycle is four clocks for gains up to 16, else two
// - sampling switch opens before discharge switch closes at gains up to 16, on the same edge above 16; never overlapping
// - self gain calibration opens mux and routes references to inputs
// - self gain calibration works with the buffer on or off
// - results are 24-bit two's complement, saturating at full scale
// - a sync event aborts the conversion and restarts both stages
`timescale 1ns/1ps
module saf_top import saf_pkg::*; (
   input  wire logic              ref_clk_i,
   input  wire logic              reset_i,
   input  wire logic              mod_bit_i,
   input  wire logic              sync_powerdown_n_i,
   input  wire logic              sync_cmd_i,
   input  wire logic              self_gain_cal_i,
   input  wire logic              reg_wr_i,
   input  wire logic [1:0]        reg_addr_i,
   input  wire logic [7:0]        reg_wdata_i,
   output logic      [7:0]        reg_rdata_o,
   output logic                   input_buffer_enable_o,
   output logic      [2:0]        pga_gain_o,
   output logic                   sampling_switch_o,
   output logic                   discharge_switch_o,
   output logic                   mux_switches_open_o,
   output logic                   ref_to_inputs_o,
   output logic                   modulator_strobe_o,
   output logic                   data_valid_o,
   input  wire logic              data_ready_i,
   output logic      [DATA_W-1:0] data_o,
   output logic                   data_overrun_o
);

   // -----------------------------------------------------------------
   // types and declarations
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DIV  = 2'b01,
      ST_HOLD = 2'b10
   } saf_div_st_t;

   saf_div_st_t               div_st_q;
   logic [7:0]                rate_code_field_q;
   logic [CNT_W-1:0]          avg_cnt_q;
   logic                      input_buffer_enable_bit_q;
   logic [2:0]                gain_q;
   logic [1:0]                mod_ph_q;
   logic [1:0]                sw_ph_q;
   logic                      sync_pin_q;
   logic                      sync_evt;
   logic                      restart;
   logic                      rate_change;
   logic [CNT_W:0]            rate_dec;
   logic signed [SINC_W-1:0]  sinc_res;
   logic                      sinc_valid;
   logic [2:0]                settle_q;
   logic                      stage1_ok;
   logic signed [ACC_W-1:0]   acc_q;
   logic signed [ACC_W-1:0]   acc_sum;
   logic [CNT_W-1:0]          n_q;
   logic                      block_done;
   logic [ACC_W-1:0]          dvd_q;
   logic [ACC_W-1:0]          quo_q;
   logic [CNT_W:0]            rem_q;
   logic [CNT_W:0]            rem_sh;
   logic [CNT_W-1:0]          div_by_q;
   logic                      neg_q;
   logic [5:0]                step_q;
   logic [DATA_W-1:0]         res_q;
   logic                      buf_ready;
   logic                      buf_valid;

   function automatic logic [ACC_W-1:0] abs_acc(input logic signed [ACC_W-1:0] v);
      abs_acc = v[ACC_W-1] ? ACC_W'(-v) : ACC_W'(v);
   endfunction

   // rescale the normalized average to 24 bits and clip at full scale
   function automatic logic [DATA_W-1:0] to_code(input logic [ACC_W-1:0] mag,
                                                 input logic neg);
      logic [ACC_W-1:0] m;
      m = mag >> OUT_SHIFT;
      if (!neg) begin
         to_code = (m > ACC_W'(24'h7fffff)) ? 24'h7fffff : m[DATA_W-1:0];
      end else begin
         to_code = (m > ACC_W'(24'h800000)) ? 24'h800000 : DATA_W'(-m[DATA_W-1:0]);
      end
   endfunction

   // -----------------------------------------------------------------
   // register port
   // -----------------------------------------------------------------
   assign rate_dec    = rate_decode(reg_wdata_i);
   assign rate_change = reg_wr_i && (reg_addr_i == ADDR_RATE) && rate_dec[CNT_W]
                        && (rate_dec[CNT_W-1:0] != avg_cnt_q);

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         rate_code_field_q <= RATE_RESET;
         avg_cnt_q         <= CNT_RESET;
      end else if (reg_wr_i && (reg_addr_i == ADDR_RATE)) begin
         rate_code_field_q <= reg_wdata_i;
         if (rate_dec[CNT_W]) begin
            avg_cnt_q <= rate_dec[CNT_W-1:0];
         end // otherwise the last valid count stays
      end
   end

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         input_buffer_enable_bit_q <= 1'b0;
         gain_q                    <= GAIN_RESET;
      end else if (reg_wr_i) begin
         if (reg_addr_i == ADDR_STATUS) begin
            input_buffer_enable_bit_q <= reg_wdata_i[INPUT_BUFFER_ENABLE_BIT_POS];
         end
         if (reg_addr_i == ADDR_CTRL) begin
            gain_q <= reg_wdata_i[2:0];
         end
      end
   end

   always_comb begin
      reg_rdata_o = 8'h00;
      unique case (reg_addr_i)
         ADDR_STATUS: begin
            reg_rdata_o[INPUT_BUFFER_ENABLE_BIT_POS] = input_buffer_enable_bit_q;
            reg_rdata_o[READY_POS] = buf_valid;
         end
         ADDR_CTRL:   reg_rdata_o = {5'h00, gain_q};
         ADDR_RATE:   reg_rdata_o = rate_code_field_q;
         default:     reg_rdata_o = 8'h00;
      endcase
   end

   // -----------------------------------------------------------------
   // analog front-end control
   // -----------------------------------------------------------------
   // buffer choice is independent of calibration
   assign input_buffer_enable_o = input_buffer_enable_bit_q;
   assign pga_gain_o            = gain_q;
   assign mux_switches_open_o   = self_gain_cal_i;
   assign ref_to_inputs_o       = self_gain_cal_i;

   // four-clock cycle leaves an idle clock between switch phases; the
   // two-clock cycle has none, both outputs change on the same edge
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         sw_ph_q            <= 2'h0;
         sampling_switch_o  <= 1'b0;
         discharge_switch_o <= 1'b0;
      end else begin
         if (gain_q >= GAIN_FAST) begin
            sw_ph_q            <= (sw_ph_q >= PERIOD_HI) ? 2'h0 : sw_ph_q + 2'h1;
            sampling_switch_o  <= (sw_ph_q == PERIOD_HI);
            discharge_switch_o <= (sw_ph_q != PERIOD_HI);
         end else begin
            sw_ph_q            <= (sw_ph_q == PERIOD_LO) ? 2'h0 : sw_ph_q + 2'h1;
            sampling_switch_o  <= (sw_ph_q == PERIOD_LO);
            discharge_switch_o <= (sw_ph_q == 2'h1);
         end
      end
   end

   // -----------------------------------------------------------------
   // sync and modulator pacing
   // -----------------------------------------------------------------
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         sync_pin_q <= 1'b1;
      end else begin
         sync_pin_q <= sync_powerdown_n_i;
      end
   end

   // filter is held while the pin is low and restarts from its rising edge
   assign sync_evt = !sync_powerdown_n_i || sync_cmd_i;
   assign restart  = sync_evt || rate_change;

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         mod_ph_q <= 2'h0;
      end else if (sync_evt) begin
         mod_ph_q <= 2'h0;
      end else begin
         mod_ph_q <= mod_ph_q + 2'h1;
      end
   end

   assign modulator_strobe_o = (mod_ph_q == 2'(MOD_DIV - 1)) && sync_pin_q;

   // -----------------------------------------------------------------
   // first stage
   // -----------------------------------------------------------------
   saf_sinc5 u_sinc5 (
      .ref_clk_i      (ref_clk_i),
      .reset_i        (reset_i),
      .clear_i        (sync_evt),
      .sample_en_i    (modulator_strobe_o),
      .bit_i          (mod_bit_i),
      .result_o       (sinc_res),
      .result_valid_o (sinc_valid)
   );

   // the first results after a sync event are still built on the cleared filter state
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         settle_q <= 3'h0;
      end else if (sync_evt) begin
         settle_q <= 3'h0;
      end else if (sinc_valid && (settle_q != SETTLE_N)) begin
         settle_q <= settle_q + 3'h1;
      end
   end

   assign stage1_ok = sinc_valid && (settle_q == SETTLE_N);

   // -----------------------------------------------------------------
   // averager
   // -----------------------------------------------------------------
   assign acc_sum    = acc_q + ACC_W'(sinc_res);
   assign block_done = stage1_ok && (n_q == avg_cnt_q - CNT_W'(1));

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         acc_q <= '0;
         n_q   <= '0;
      end else if (restart) begin
         acc_q <= '0;
         n_q   <= '0;
      end else if (block_done) begin
         acc_q <= '0;
         n_q   <= '0;
      end else if (stage1_ok) begin
         acc_q <= acc_sum;
         n_q   <= n_q + CNT_W'(1);
      end
   end

   // -----------------------------------------------------------------
   // normalizing divider
   // -----------------------------------------------------------------
   // sequential so one small subtractor serves every count; it needs
   // fewer clocks than the shortest output period
   assign rem_sh = {rem_q[CNT_W-1:0], dvd_q[ACC_W-1]};

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         div_st_q <= ST_IDLE;
         dvd_q    <= '0;
         quo_q    <= '0;
         rem_q    <= '0;
         div_by_q <= CNT_RESET;
         neg_q    <= 1'b0;
         step_q   <= 6'h0;
         res_q    <= '0;
      end else if (sync_evt) begin
         div_st_q <= ST_IDLE;
      end else begin
         unique case (div_st_q)
            ST_IDLE: begin
               if (block_done) begin
                  dvd_q    <= abs_acc(acc_sum);
                  neg_q    <= acc_sum[ACC_W-1];
                  div_by_q <= avg_cnt_q;
                  quo_q    <= '0;
                  rem_q    <= '0;
                  step_q   <= 6'h0;
                  div_st_q <= ST_DIV;
               end
            end
            ST_DIV: begin
               dvd_q  <= {dvd_q[ACC_W-2:0], 1'b0};
               step_q <= step_q + 6'h1;
               if (rem_sh >= {1'b0, div_by_q}) begin
                  rem_q <= rem_sh - {1'b0, div_by_q};
                  quo_q <= {quo_q[ACC_W-2:0], 1'b1};
               end else begin
                  rem_q <= rem_sh;
                  quo_q <= {quo_q[ACC_W-2:0], 1'b0};
               end
               if (step_q == DIV_STEPS - 6'h1) begin
                  div_st_q <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               res_q <= to_code(quo_q, neg_q);
               if (buf_ready && hold_seen_q) begin
                  div_st_q <= ST_IDLE;
               end
            end
            default: div_st_q <= ST_IDLE;
         endcase
      end
   end

   // a block that finishes while the previous one is still waiting is lost
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         data_overrun_o <= 1'b0;
      end else begin
         data_overrun_o <= block_done && (div_st_q != ST_IDLE) && !sync_evt;
      end
   end

   // -----------------------------------------------------------------
   // output buffer
   // -----------------------------------------------------------------
   // res_q settles in the first hold cycle, so push only from the second
   logic hold_seen_q;

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         hold_seen_q <= 1'b0;
      end else begin
         hold_seen_q <= (div_st_q == ST_HOLD) && !(buf_ready && hold_seen_q) && !sync_evt;
      end
   end

   saf_buf2 #(
      .WIDTH (DATA_W),
      .DEPTH (2)
   ) u_buf (
      .ref_clk_i   (ref_clk_i),
      .reset_i     (reset_i),
      .flush_i     (sync_evt),
      .in_valid_i  ((div_st_q == ST_HOLD) && hold_seen_q),
      .in_ready_o  (buf_ready),
      .in_data_i   (res_q),
      .out_valid_o (buf_valid),
      .out_ready_i (data_ready_i),
      .out_data_o  (data_o)
   );

   assign data_valid_o = buf_valid;

endmodule

/* verification/saf_monitor.sv */
// port checker for saf_top
// assumes it is bound onto saf_top and sees only its ports
`timescale 1ns/1ps
module saf_monitor import saf_pkg::*; (
   input wire logic       ref_clk_i, reset_i, sync_powerdown_n_i, sync_cmd_i,
   input wire logic       self_gain_cal_i, reg_wr_i, data_ready_i, sampling_switch_o,
   input wire logic       discharge_switch_o, mux_switches_open_o, ref_to_inputs_o,
   input wire logic       modulator_strobe_o, data_valid_o,
   input wire logic [1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i, reg_rdata_o,
   input wire logic [2:0] pga_gain_o,
   input wire logic [DATA_W-1:0] data_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   sequence slow_cyc;
      !sampling_switch_o && !discharge_switch_o ##1 discharge_switch_o
      ##1 !sampling_switch_o && !discharge_switch_o ##1 sampling_switch_o;
   endsequence
   sequence fast_cyc;
      discharge_switch_o && !sampling_switch_o ##1 sampling_switch_o;
   endsequence
   // a gain write mid-cycle may legally reshape the cycle in flight
   sequence gain_moves;
      ##[0:3] $changed(pga_gain_o);
   endsequence
   a_strobe_gap: assert property (modulator_strobe_o |=> !modulator_strobe_o [*3])
      else $error("modulator strobe closer than four clocks");
   a_strobe_sync: assert property (!sync_powerdown_n_i |=> !modulator_strobe_o)
      else $error("strobe while sync pin low");
   a_switch_apart: assert property (!(sampling_switch_o && discharge_switch_o))
      else $error("sampling and discharge switches overlap");
   a_slow_cycle: assert property (sampling_switch_o && pga_gain_o < GAIN_FAST
      && $past(pga_gain_o, 4) == pga_gain_o |=> slow_cyc or gain_moves)
      else $error("low gain switch cycle is not four clocks");
   a_fast_cycle: assert property (sampling_switch_o && pga_gain_o >= GAIN_FAST
      && $past(pga_gain_o, 2) == pga_gain_o |=> fast_cyc or gain_moves)
      else $error("high gain switch cycle is not two clocks");
   a_cal_route: assert property (mux_switches_open_o == self_gain_cal_i
      && ref_to_inputs_o == self_gain_cal_i)
      else $error("calibration routing does not follow request");
   a_sync_flush: assert property (!sync_powerdown_n_i || sync_cmd_i |=> !data_valid_o)
      else $error("data left after sync");
   a_data_hold: assert property (data_valid_o && !data_ready_i && sync_powerdown_n_i
      && !sync_cmd_i |=> data_valid_o && $stable(data_o))
      else $error("unread word changed or vanished");
   a_rate_back: assert property (reg_wr_i && reg_addr_i == ADDR_RATE |=>
      reg_addr_i != ADDR_RATE || reg_rdata_o == $past(reg_wdata_i))
      else $error("rate code not read back");
   a_gain_write: assert property (reg_wr_i && reg_addr_i == ADDR_CTRL |=>
      pga_gain_o == 3'($past(reg_wdata_i)))
      else $error("gain does not follow control write");
endmodule
bind saf_top saf_monitor mon_u (.ref_clk_i, .reset_i, .sync_powerdown_n_i, .sync_cmd_i,
   .self_gain_cal_i, .reg_wr_i, .data_ready_i, .sampling_switch_o, .discharge_switch_o,
   .mux_switches_open_o, .ref_to_inputs_o, .modulator_strobe_o, .data_valid_o,
   .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .pga_gain_o, .data_o);

/* verification/saf_mod_model.sv */
// modulator stand-in: one bitstream bit per strobe
// assumes the strobe comes from the block under test
`timescale 1ns/1ps
module saf_mod_model (
   input  wire logic ref_clk_i,
   input  wire logic strobe_i,
   input  wire logic toggle_i,
   output logic      bit_o
);
   initial bit_o = 1'b1;
   // full scale ones unless toggling; new bit lands after the taking edge
   always @(posedge ref_clk_i) if (strobe_i) bit_o <= #1 (toggle_i ? ~bit_o : 1'b1);
endmodule

/* verification/saf_top_tb_top.sv */
// self-checking bench for saf_top
// assumes saf_monitor is bound in and saf_mod_model feeds the bitstream
`timescale 1ns/1ps
module saf_top_tb_top import saf_pkg::*;;
   logic ref_clk_i = 1'b0, reset_i = 1'b1, sync_powerdown_n_i = 1'b1, sync_cmd_i = 1'b0;
   logic self_gain_cal_i = 1'b0, reg_wr_i = 1'b0, data_ready_i = 1'b1, tog = 1'b0;
   logic mod_bit_i, input_buffer_enable_o, sampling_switch_o, discharge_switch_o;
   logic mux_switches_open_o, ref_to_inputs_o, modulator_strobe_o, data_valid_o, data_overrun_o;
   logic [1:0] reg_addr_i = 2'h0;
   logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o;
   logic [2:0] pga_gain_o;
   logic [DATA_W-1:0] data_o;
   int num_errors = 0;
   int check_count = 0;
   int n;
   always #50 ref_clk_i = ~ref_clk_i;
   saf_top dut_u (.ref_clk_i, .reset_i, .mod_bit_i, .sync_powerdown_n_i, .sync_cmd_i,
      .self_gain_cal_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
      .input_buffer_enable_o, .pga_gain_o, .sampling_switch_o, .discharge_switch_o,
      .mux_switches_open_o, .ref_to_inputs_o, .modulator_strobe_o, .data_valid_o,
      .data_ready_i, .data_o, .data_overrun_o);
   saf_mod_model mod_u (.ref_clk_i, .strobe_i(modulator_strobe_o), .toggle_i(tog),
      .bit_o(mod_bit_i));
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk_i);
      #1;
   endtask
   // lowering the strobe is followed by a clock so back-to-back calls never clash
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      reg_wr_i = 1'b1;
      reg_addr_i = a;
      reg_wdata_i = d;
      tick(1);
      reg_wr_i = 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      reg_addr_i = a;
      #1 chk(24'(reg_rdata_o), 24'(e));
   endtask
   task automatic wait_valid(output int k);
      k = 0;
      do begin
         tick(1);
         k++;
      end while (data_valid_o !== 1'b1 && k < 20000);
      chk(24'(k < 20000), 24'h1);
   endtask
   task automatic t_regs();
      logic [7:0] codes [16] = '{8'h03, 8'h13, 8'h23, 8'h33, 8'h43, 8'h53, 8'h63, 8'h72,
                                8'h82, 8'h92, 8'ha1, 8'hb0, 8'hc0, 8'hd0, 8'he0, 8'hf0};
      rd(ADDR_RATE, RATE_RESET);
      rd(ADDR_STATUS, 8'h00);
      wr(2'h1, 8'hff);
      rd(2'h1, 8'h00);
      for (int g = 0; g < 8; g++) begin
         wr(ADDR_CTRL, 8'(g));
         chk(24'(pga_gain_o), 24'(g));
         tick(12);
      end
      foreach (codes[i]) begin
         wr(ADDR_RATE, codes[i]);
         rd(ADDR_RATE, codes[i]);
      end
   endtask
   task automatic t_cal();
      for (int b = 0; b < 2; b++) begin
         wr(ADDR_STATUS, 8'(b << INPUT_BUFFER_ENABLE_BIT_POS));
         chk(24'(input_buffer_enable_o), 24'(b));
         self_gain_cal_i = 1'b1;
         tick(1);
         chk(24'({mux_switches_open_o, ref_to_inputs_o}), 24'h3);
         self_gain_cal_i = 1'b0;
         tick(1);
         chk(24'({mux_switches_open_o, ref_to_inputs_o}), 24'h0);
      end
   endtask
   // spacing of results is measured between the second and third after a change
   task automatic t_rates();
      logic [7:0] rc [5] = '{8'hf0, 8'he0, 8'hd0, 8'hc0, 8'h55};
      int cnt [5] = '{1, 2, 4, 8, 8};
      foreach (rc[i]) begin
         wr(ADDR_RATE, rc[i]);
         repeat (3) wait_valid(n);
         chk(24'(n), 24'(SINC_DECIM * MOD_DIV * cnt[i]));
         chk(data_o, 24'h7fffff);
      end
   endtask
   task automatic t_stall();
      wr(ADDR_RATE, 8'hf0);
      data_ready_i = 1'b0;
      tog = 1'b1;
      n = 0;
      do begin
         tick(1);
         n++;
      end while (data_overrun_o !== 1'b1 && n < 2000);
      chk(24'(data_overrun_o), 24'h1);
      rd(ADDR_STATUS, 8'h03);
      data_ready_i = 1'b1;
      n = 0;
      repeat (10) begin
         if (data_valid_o === 1'b1) n++;
         tick(1);
      end
      chk(24'(n), 24'h3);
      tog = 1'b0;
   endtask
   task automatic t_sync();
      data_ready_i = 1'b0;
      wait_valid(n);
      sync_cmd_i = 1'b1;
      tick(1);
      sync_cmd_i = 1'b0;
      chk(24'(data_valid_o), 24'h0);
      sync_powerdown_n_i = 1'b0;
      tick(3);
      chk(24'({data_valid_o, modulator_strobe_o}), 24'h0);
      sync_powerdown_n_i = 1'b1;
      data_ready_i = 1'b1;
      wait_valid(n);
      chk(24'(n >= 5 * SINC_DECIM * MOD_DIV), 24'h1);
   endtask
   task automatic conclude();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      tick(4);
      reset_i = 1'b0;
      t_regs();
      t_cal();
      t_rates();
      t_stall();
      t_sync();
      conclude();
   end
   initial begin
      #(100 * 60000);
      num_errors++;
      conclude();
   end
endmodule
